/* File: design/servo_pkg.sv */
package servo_pkg;

  // Clock and input filter timing.
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEBOUNCE_NS = 100000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W = 12;
  localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEBOUNCE_CYCLES - 1);

  // Warning thresholds in percent of the protection level.
  localparam logic [22:0] PCT_WARN = 23'h000055;
  localparam logic [22:0] PCT_FULL = 23'h000064;

  // Register byte offsets.
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_WARN_SEL = 8'h04;
  localparam logic [7:0] OFS_ZERO_THR = 8'h08;
  localparam logic [7:0] OFS_PRESET_ONE = 8'h0c;
  localparam logic [7:0] OFS_PRESET_TWO = 8'h10;
  localparam logic [7:0] OFS_PRESET_THREE = 8'h14;
  localparam logic [7:0] OFS_PRESET_FOUR = 8'h18;
  localparam logic [7:0] OFS_ACCEL = 8'h1c;
  localparam logic [7:0] OFS_DECEL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MONITOR = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // Field positions.
  localparam int MODE_POL_BIT = 4;
  localparam int MON_SERVO_BIT = 0;
  localparam int MON_CLAMP_BIT = 5;
  localparam int MON_SEL_LOW_BIT = 6;
  localparam int MON_SEL_HIGH_BIT = 7;
  localparam int IRQ_WARN_BIT = 0;
  localparam int IRQ_SERVO_OFF_BIT = 1;
  localparam int IRQ_CLAMP_OPEN_BIT = 2;

  // Reset values and codes.
  localparam logic [3:0] MODE_RESET = 4'h2;
  localparam logic [3:0] MODE_INTERNAL_VELOCITY = 4'h1;
  localparam logic [2:0] WARN_SEL_RESET = 3'h0;
  localparam logic [15:0] ZERO_THR_RESET = 16'h0032;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] RAMP_RESET = 16'h0000;

  localparam logic [2:0] WSEL_TORQUE_LIMIT = 3'h0;
  localparam logic [2:0] WSEL_ZERO_SPEED = 3'h1;
  localparam logic [2:0] WSEL_ANY_WARNING = 3'h2;
  localparam logic [2:0] WSEL_REGEN = 3'h3;
  localparam logic [2:0] WSEL_OVERLOAD = 3'h4;
  localparam logic [2:0] WSEL_NONE = 3'h5;
  localparam logic [2:0] WSEL_FAN = 3'h6;

  typedef struct packed {
    logic servo_enable_in;
    logic speed_zero_clamp_in;
    logic speed_select_bit_high;
    logic speed_select_bit_low;
  } ctrl_inputs_t;

  typedef struct packed {
    logic torque_limited;
    logic signed [15:0] motor_speed;
    logic [15:0] regen_load;
    logic [15:0] regen_fault_level;
    logic [15:0] effective_torque;
    logic [15:0] overload_level;
    logic fan_stopped;
  } drive_status_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] clean;
    logic [3:0][DEB_CNT_W-1:0] cnt;
  } deb_state_t;

  typedef struct packed {
    logic [3:0] control_mode_setting;
    logic pulse_output_polarity_invert;
    logic [2:0] warning_output_select;
    logic [15:0] zero_speed_threshold;
    logic [3:0][15:0] speed_preset;
    logic [15:0] accel_ramp_time;
    logic [15:0] decel_ramp_time;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    logic warning;
    logic phase_a;
    logic phase_b;
    logic signed [15:0] speed_cmd;
    logic [15:0] ramp_cnt;
    logic motor_en;
    logic prev_servo;
    logic prev_clamp;
  } servo_state_t;

endpackage

/* File: design/input_conditioner.sv */
`timescale 1ns/1ps
`default_nettype none
module input_conditioner
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Raw pins, high when the contact is closed
  input wire servo_pkg::ctrl_inputs_t i_raw,
  // Filtered levels
  output var servo_pkg::ctrl_inputs_t o_clean
);
  import servo_pkg::*;

  deb_state_t st_reg;
  deb_state_t st_next;

  // A level is accepted only after it has held for the full filter time.
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = i_raw;
    st_next.sync2 = st_reg.sync1;
    for (int i = 0; i < 4; i++)
    begin
      if (st_reg.sync2[i] == st_reg.clean[i])
      begin
        st_next.cnt[i] = '0;
      end
      else if (st_reg.cnt[i] == DEB_LAST)
      begin
        st_next.clean[i] = st_reg.sync2[i];
        st_next.cnt[i] = '0;
      end
      else
      begin
        st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_clean = st_reg.clean;

endmodule
`default_nettype wire

/* File: design/servo_warn_speed.sv */
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module servo_warn_speed
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Host control pins
  input wire servo_pkg::ctrl_inputs_t i_ctrl_pins,
  // Drive conditions from the power stage
  input wire servo_pkg::drive_status_t i_drive,
  // Divided encoder pulses from the divider
  input wire logic i_enc_phase_a,
  input wire logic i_enc_phase_b,
  // Outputs
  output logic o_warning,
  output logic o_divided_phase_a_out,
  output logic o_divided_phase_b_out,
  output logic o_motor_enable,
  output logic signed [15:0] o_speed_cmd,
  output logic o_irq
);
  import servo_pkg::*;

  servo_state_t st_reg;
  servo_state_t st_next;
  ctrl_inputs_t clean;
  logic busy;
  logic regen_warn;
  logic overload_warn;
  logic zero_speed;
  logic [16:0] speed_mag;
  logic signed [15:0] target;
  logic run_ok;

  function automatic logic above_pct(input logic [15:0] value, input logic [15:0] level);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(value) * PCT_FULL;
    rhs = 23'(level) * PCT_WARN;
    return lhs > rhs;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0])
    begin
      res[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic [16:0] abs17(input logic signed [15:0] v);
    logic [16:0] ext;
    ext = {v[15], v};
    return v[15] ? 17'(-ext) : ext;
  endfunction

  input_conditioner u_cond
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw(i_ctrl_pins),
    .o_clean(clean)
  );

  assign busy = i_avs_read || i_avs_write;
  assign regen_warn = above_pct(i_drive.regen_load, i_drive.regen_fault_level);
  assign overload_warn = above_pct(i_drive.effective_torque, i_drive.overload_level);
  assign speed_mag = abs17(i_drive.motor_speed);
  assign zero_speed = speed_mag < {1'b0, st_reg.zero_speed_threshold};
  assign run_ok = clean.servo_enable_in && clean.speed_zero_clamp_in;

  always_comb
  begin
    target = 16'sh0000;
    if (st_reg.control_mode_setting == MODE_INTERNAL_VELOCITY && run_ok)
    begin
      target = st_reg.speed_preset[{clean.speed_select_bit_high,
                                    clean.speed_select_bit_low}];
    end
  end

  always_comb
  begin
    logic [15:0] rate;
    logic away;
    logic [2:0] events;
    logic [2:0] clear;
    st_next = st_reg;
    rate = '0;
    away = 1'b0;
    events = '0;
    clear = '0;

    // One wait state: read data is captured, then the answer is released.
    st_next.ack = busy && !st_reg.ack;
    if (busy && !st_reg.ack)
    begin
      case (i_avs_address)
        OFS_MODE: st_next.rdata = {27'h0, st_reg.pulse_output_polarity_invert,
                                   st_reg.control_mode_setting};
        OFS_WARN_SEL: st_next.rdata = {29'h0, st_reg.warning_output_select};
        OFS_ZERO_THR: st_next.rdata = {16'h0, st_reg.zero_speed_threshold};
        OFS_PRESET_ONE: st_next.rdata = {16'h0, st_reg.speed_preset[0]};
        OFS_PRESET_TWO: st_next.rdata = {16'h0, st_reg.speed_preset[1]};
        OFS_PRESET_THREE: st_next.rdata = {16'h0, st_reg.speed_preset[2]};
        OFS_PRESET_FOUR: st_next.rdata = {16'h0, st_reg.speed_preset[3]};
        OFS_ACCEL: st_next.rdata = {16'h0, st_reg.accel_ramp_time};
        OFS_DECEL: st_next.rdata = {16'h0, st_reg.decel_ramp_time};
        OFS_STATUS: st_next.rdata = {9'h0, i_drive.torque_limited, zero_speed,
                                     regen_warn, overload_warn, i_drive.fan_stopped,
                                     st_reg.motor_en, st_reg.warning,
                                     st_reg.speed_cmd};
        OFS_MONITOR:
        begin
          st_next.rdata = 32'h0;
          st_next.rdata[MON_SERVO_BIT] = clean.servo_enable_in;
          st_next.rdata[MON_CLAMP_BIT] = clean.speed_zero_clamp_in;
          st_next.rdata[MON_SEL_LOW_BIT] = clean.speed_select_bit_low;
          st_next.rdata[MON_SEL_HIGH_BIT] = clean.speed_select_bit_high;
        end
        OFS_IRQ_STATUS: st_next.rdata = {29'h0, st_reg.irq_status};
        OFS_IRQ_MASK: st_next.rdata = {29'h0, st_reg.irq_mask};
        default: st_next.rdata = 32'h0;
      endcase
    end

    if (st_reg.ack && i_avs_write)
    begin
      case (i_avs_address)
        OFS_MODE:
        begin
          if (i_avs_byteenable[0])
          begin
            st_next.control_mode_setting = i_avs_writedata[3:0];
            st_next.pulse_output_polarity_invert = i_avs_writedata[MODE_POL_BIT];
          end
        end
        OFS_WARN_SEL:
        begin
          if (i_avs_byteenable[0])
          begin
            st_next.warning_output_select = i_avs_writedata[2:0];
          end
        end
        OFS_ZERO_THR: st_next.zero_speed_threshold =
          merge16(st_reg.zero_speed_threshold, i_avs_writedata, i_avs_byteenable);
        OFS_PRESET_ONE: st_next.speed_preset[0] =
          merge16(st_reg.speed_preset[0], i_avs_writedata, i_avs_byteenable);
        OFS_PRESET_TWO: st_next.speed_preset[1] =
          merge16(st_reg.speed_preset[1], i_avs_writedata, i_avs_byteenable);
        OFS_PRESET_THREE: st_next.speed_preset[2] =
          merge16(st_reg.speed_preset[2], i_avs_writedata, i_avs_byteenable);
        OFS_PRESET_FOUR: st_next.speed_preset[3] =
          merge16(st_reg.speed_preset[3], i_avs_writedata, i_avs_byteenable);
        OFS_ACCEL: st_next.accel_ramp_time =
          merge16(st_reg.accel_ramp_time, i_avs_writedata, i_avs_byteenable);
        OFS_DECEL: st_next.decel_ramp_time =
          merge16(st_reg.decel_ramp_time, i_avs_writedata, i_avs_byteenable);
        OFS_IRQ_STATUS:
        begin
          if (i_avs_byteenable[0])
          begin
            clear = i_avs_writedata[2:0];
          end
        end
        OFS_IRQ_MASK:
        begin
          if (i_avs_byteenable[0])
          begin
            st_next.irq_mask = i_avs_writedata[2:0];
          end
        end
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end

    // Warning selector; code 5 and unused codes keep the output off.
    case (st_reg.warning_output_select)
      WSEL_TORQUE_LIMIT: st_next.warning = i_drive.torque_limited;
      WSEL_ZERO_SPEED: st_next.warning = zero_speed;
      WSEL_ANY_WARNING: st_next.warning = regen_warn || overload_warn ||
                                          i_drive.fan_stopped;
      WSEL_REGEN: st_next.warning = regen_warn;
      WSEL_OVERLOAD: st_next.warning = overload_warn;
      WSEL_NONE: st_next.warning = 1'b0;
      WSEL_FAN: st_next.warning = i_drive.fan_stopped;
      default: st_next.warning = 1'b0;
    endcase

    st_next.phase_a = i_enc_phase_a;
    st_next.phase_b = i_enc_phase_b ^ st_reg.pulse_output_polarity_invert;
    st_next.motor_en = clean.servo_enable_in;

    // Moving away from zero uses the accel time, toward zero the decel time.
    // A ramp time counts clock cycles per unit step of the speed command.
    if (st_reg.speed_cmd == target)
    begin
      st_next.ramp_cnt = '0;
    end
    else
    begin
      away = (st_reg.speed_cmd == 16'sh0000) ||
             ((st_reg.speed_cmd[15] == target[15]) &&
              (abs17(target) > abs17(st_reg.speed_cmd)));
      rate = away ? st_reg.accel_ramp_time : st_reg.decel_ramp_time;
      if (rate == 16'h0000)
      begin
        st_next.speed_cmd = target;
        st_next.ramp_cnt = '0;
      end
      else if (st_reg.ramp_cnt >= rate - 16'h0001)
      begin
        st_next.ramp_cnt = '0;
        st_next.speed_cmd = (target > st_reg.speed_cmd) ? st_reg.speed_cmd + 16'sh0001
                                                        : st_reg.speed_cmd - 16'sh0001;
      end
      else
      begin
        st_next.ramp_cnt = st_reg.ramp_cnt + 16'h0001;
      end
    end

    st_next.prev_servo = clean.servo_enable_in;
    st_next.prev_clamp = clean.speed_zero_clamp_in;
    events[IRQ_WARN_BIT] = st_next.warning && !st_reg.warning;
    events[IRQ_SERVO_OFF_BIT] = st_reg.prev_servo && !clean.servo_enable_in;
    events[IRQ_CLAMP_OPEN_BIT] = st_reg.prev_clamp && !clean.speed_zero_clamp_in;
    // A new event in the clearing cycle keeps its bit set.
    st_next.irq_status = (st_reg.irq_status & ~clear) | events;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
      st_reg.control_mode_setting <= MODE_RESET;
      st_reg.warning_output_select <= WARN_SEL_RESET;
      st_reg.zero_speed_threshold <= ZERO_THR_RESET;
      st_reg.speed_preset <= {4{PRESET_RESET}};
      st_reg.accel_ramp_time <= RAMP_RESET;
      st_reg.decel_ramp_time <= RAMP_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_avs_waitrequest = busy && !st_reg.ack;
  assign o_avs_readdata = st_reg.rdata;
  assign o_warning = st_reg.warning;
  assign o_divided_phase_a_out = st_reg.phase_a;
  assign o_divided_phase_b_out = st_reg.phase_b;
  assign o_motor_enable = st_reg.motor_en;
  assign o_speed_cmd = st_reg.speed_cmd;
  assign o_irq = |(st_reg.irq_status & st_reg.irq_mask);

  AST_SEL_TORQUE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_TORQUE_LIMIT) |=>
      (o_warning == $past(i_drive.torque_limited)))
    else $error("Warning does not follow torque limiting.");

  AST_SEL_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_ZERO_SPEED) |=>
      (o_warning == $past(zero_speed)))
    else $error("Warning does not follow zero speed.");

  AST_SEL_ANY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_ANY_WARNING) |=> (o_warning == (
      32'($past(i_drive.regen_load)) * 100 > 32'($past(i_drive.regen_fault_level)) * 85 ||
      32'($past(i_drive.effective_torque)) * 100 > 32'($past(i_drive.overload_level)) * 85 ||
      $past(i_drive.fan_stopped))))
    else $error("Combined warning is not the OR of the three warnings.");

  AST_SEL_REGEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_REGEN) |=>
      (o_warning == ($past(i_drive.regen_load) * 100 > $past(i_drive.regen_fault_level) * 85)))
    else $error("Regenerative warning threshold wrong.");

  AST_SEL_OVERLOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_OVERLOAD) |=>
      (o_warning == (32'($past(i_drive.effective_torque)) * 100 >
                     32'($past(i_drive.overload_level)) * 85)))
    else $error("Overload warning threshold wrong.");

  AST_SEL_NONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_NONE) |=> !o_warning)
    else $error("Warning driven with code 5.");

  AST_SEL_FAN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.warning_output_select == WSEL_FAN) |=> (o_warning == $past(i_drive.fan_stopped)))
    else $error("Warning does not follow fan stop.");

  AST_PHASE_B: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> (o_divided_phase_b_out ==
              ($past(i_enc_phase_b) ^ $past(st_reg.pulse_output_polarity_invert))))
    else $error("Phase B polarity wrong.");

  AST_PRESET_TWO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_reg.control_mode_setting == MODE_INTERNAL_VELOCITY && run_ok &&
     clean.speed_select_bit_low && !clean.speed_select_bit_high &&
     st_reg.accel_ramp_time == 16'h0000 && st_reg.decel_ramp_time == 16'h0000) |=>
      (o_speed_cmd == $past(st_reg.speed_preset[1])))
    else $error("Second preset not selected.");

  AST_CLAMP_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!clean.speed_zero_clamp_in && st_reg.decel_ramp_time == 16'h0000 &&
     st_reg.accel_ramp_time == 16'h0000) |=> (o_speed_cmd == 16'sh0000))
    else $error("Open clamp did not stop the motor.");

  AST_SERVO_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!clean.servo_enable_in && st_reg.accel_ramp_time == 16'h0000 &&
     st_reg.decel_ramp_time == 16'h0000) |=> (!o_motor_enable && o_speed_cmd == 16'sh0000))
    else $error("Motor energised without servo enable.");

  AST_IRQ_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_next.warning && !st_reg.warning) |=> st_reg.irq_status[IRQ_WARN_BIT])
    else $error("Warning event lost.");

endmodule
`default_nettype wire

/* File: tb/host_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Contact states the host asks for
  input wire servo_pkg::ctrl_inputs_t i_want,
  // Contacts as seen at the pins
  output var servo_pkg::ctrl_inputs_t o_pins
);
  import servo_pkg::*;
  ctrl_inputs_t last_reg;
  ctrl_inputs_t flip_reg;
  logic [3:0] bounce_reg;
  // Real contacts chatter, so a change toggles for several cycles before it settles.
  // The pins take whatever contact levels the bench asks for on i_want, after the bounce.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_pins <= '0;
      last_reg <= '0;
      flip_reg <= '0;
      bounce_reg <= 4'h0;
    end
    else if (i_want != last_reg)
    begin
      last_reg <= i_want;
      flip_reg <= i_want ^ last_reg;
      bounce_reg <= 4'h8;
      o_pins <= i_want;
    end
    else if (bounce_reg != 4'h0)
    begin
      bounce_reg <= bounce_reg - 4'h1;
      o_pins <= (bounce_reg == 4'h1) ? last_reg : o_pins ^ flip_reg;
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import servo_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq, warn, pha, phb, men, irq;
  logic signed [15:0] spd;
  ctrl_inputs_t want = '0;
  ctrl_inputs_t pins;
  drive_status_t drv = '0;
  logic ea = 1'b0;
  logic eb = 1'b0;
  logic [7:0] rnd = 8'h1d;
  logic [15:0] pre [0:3];
  logic [31:0] exp_q [$];
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  servo_warn_speed servo_warn_speed_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_ctrl_pins(pins), .i_drive(drv), .i_enc_phase_a(ea), .i_enc_phase_b(eb),
    .o_warning(warn), .o_divided_phase_a_out(pha), .o_divided_phase_b_out(phb),
    .o_motor_enable(men), .o_speed_cmd(spd), .o_irq(irq));

  host_pins_model host_pins_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_want(want),
    .o_pins(pins));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic drive_status_t mk(input logic tl, input logic [15:0] sp,
    input logic [15:0] rg, input logic [15:0] tq, input logic fan);
    return '{tl, sp, rg, 16'h0064, tq, 16'h0064, fan};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request is held until an edge samples waitrequest low; only the timeout ends a hang.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wcase(input logic [2:0] code, input drive_status_t d, input logic e);
    bus(1'b1, 8'h04, {29'h0, code});
    drv <= d;
    tick(3);
    chk({31'h0, warn}, {31'h0, e}, "warning");
  endtask

  // Pin changes pass bounce, sync and the long filter before they act.
  task automatic settle(input ctrl_inputs_t w);
    want <= w;
    tick(2540);
  endtask

  always @(posedge clk)
  begin
    if (rd && waitreq === 1'b0 && exp_q.size() > 0)
      chk(rdata, exp_q.pop_front(), "read data");
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end

  initial
  begin
    pre[0] = 16'h0123;
    pre[1] = 16'hfe00;
    pre[2] = 16'h0456;
    pre[3] = 16'h7fff;
    tick(3);
    rst_n <= 1'b1;
    rdchk(8'h00, 32'h2);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h32);
    rdchk(8'h0c, 32'h0);
    rdchk(8'h1c, 32'h0);
    rdchk(8'h20, 32'h0);
    bus(1'b1, 8'h3c, 32'hffffffff);
    rdchk(8'h3c, 32'h0);
    $display("test registers done");
    wcase(3'h0, mk(1'b1, 16'd1000, 16'd0, 16'd0, 1'b0), 1'b1);
    wcase(3'h1, mk(1'b0, 16'd50, 16'd0, 16'd0, 1'b0), 1'b0);
    wcase(3'h1, mk(1'b0, -16'sd49, 16'd0, 16'd0, 1'b0), 1'b1);
    wcase(3'h2, mk(1'b1, 16'd1000, 16'd0, 16'd0, 1'b0), 1'b0);
    wcase(3'h2, mk(1'b0, 16'd1000, 16'd0, 16'd86, 1'b0), 1'b1);
    wcase(3'h2, mk(1'b0, 16'd1000, 16'd86, 16'd0, 1'b0), 1'b1);
    wcase(3'h3, mk(1'b0, 16'd1000, 16'd85, 16'd0, 1'b0), 1'b0);
    wcase(3'h3, mk(1'b0, 16'd1000, 16'd86, 16'd0, 1'b0), 1'b1);
    wcase(3'h4, mk(1'b0, 16'd1000, 16'd0, 16'd85, 1'b0), 1'b0);
    wcase(3'h4, mk(1'b0, 16'd1000, 16'd0, 16'd86, 1'b0), 1'b1);
    wcase(3'h5, mk(1'b1, 16'd0, 16'd99, 16'd99, 1'b1), 1'b0);
    wcase(3'h6, mk(1'b1, 16'd0, 16'd99, 16'd99, 1'b0), 1'b0);
    wcase(3'h6, mk(1'b0, 16'd1000, 16'd0, 16'd0, 1'b1), 1'b1);
    wcase(3'h7, mk(1'b1, 16'd0, 16'd99, 16'd99, 1'b1), 1'b0);
    wcase(3'h0, mk(1'b0, 16'd1000, 16'd0, 16'd0, 1'b0), 1'b0);
    $display("test warning codes done");
    bus(1'b1, 8'h2c, 32'h7);
    bus(1'b1, 8'h30, 32'h1);
    drv <= mk(1'b1, 16'd1000, 16'd0, 16'd0, 1'b0);
    tick(4);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rdchk(8'h2c, 32'h1);
    bus(1'b1, 8'h30, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, 8'h2c, 32'h1);
    rdchk(8'h2c, 32'h0);
    $display("test interrupt done");
    for (int p = 0; p < 2; p++)
    begin
      bus(1'b1, 8'h00, {27'h0, p[0], 4'h1});
      repeat (16)
      begin
        rnd = lfsr(rnd);
        ea <= rnd[0];
        eb <= rnd[1];
        tick(2);
        chk({30'h0, pha, phb}, {30'h0, rnd[0], rnd[1] ^ p[0]}, "phase");
      end
    end
    $display("test pulse polarity done");
    for (int i = 0; i < 4; i++)
      bus(1'b1, 8'h0c + 8'(4 * i), {16'h0, pre[i]});
    for (int s = 0; s < 4; s++)
    begin
      settle({1'b1, 1'b1, s[1], s[0]});
      chk(sx(spd), sx(pre[s]), "preset speed");
    end
    chk({31'h0, men}, 32'h1, "motor enable");
    rdchk(8'h28, 32'he1);
    want <= '{1'b1, 1'b1, 1'b0, 1'b0};
    tick(200);
    rdchk(8'h28, 32'he1);
    chk(sx(spd), sx(pre[3]), "filtered speed");
    tick(2400);
    chk(sx(spd), sx(pre[0]), "preset one");
    bus(1'b1, 8'h20, 32'h4);
    bus(1'b1, 8'h00, 32'h2);
    tick(8);
    chk({31'h0, spd > 0 && spd < 16'sh0123}, 32'h1, "decel ramp");
    bus(1'b1, 8'h20, 32'h0);
    tick(3);
    chk(sx(spd), 32'h0, "mode off");
    bus(1'b1, 8'h00, 32'h1);
    tick(3);
    chk(sx(spd), sx(pre[0]), "mode on");
    $display("test speed select done");
    bus(1'b1, 8'h2c, 32'h7);
    bus(1'b1, 8'h30, 32'h4);
    settle('{1'b1, 1'b0, 1'b0, 1'b0});
    chk(sx(spd), 32'h0, "clamp stop");
    chk({31'h0, men}, 32'h1, "enable kept");
    chk({31'h0, irq}, 32'h1, "clamp irq");
    rdchk(8'h2c, 32'h4);
    settle('0);
    chk({31'h0, men}, 32'h0, "servo off");
    rdchk(8'h28, 32'h0);
    $display("test clamp and servo done");
    results();
  end
endmodule
`default_nettype wire
